// ===== common/ssp_pkg.sv
// constants and carriers for the serial port pin block
// assumes a 25 MHz register clock and an APB master with 32-bit data
// Function
// - shift receive pin on receive clock
// - software reads receive clock pin level while port disabled
// - select zero: transmit clock is input
// - select one: drive quarter-rate transmit clock
// - software reads transmit clock pin level while port disabled
// - drivers-off floats transmit clock pin
// - receive from standard or multiplexed pin
// - frame-sync falling edge starts receive
package ssp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] SSP_CTRL_OFS = 12'h000;
    localparam logic [11:0] SSP_STAT_OFS = 12'h004;
    localparam logic [11:0] SSP_DATA_OFS = 12'h008;
    localparam logic [2:0] SSP_CTRL_RST = 3'h0;
    // control fields
    localparam int SSP_CTRL_CLKSRC = 0;
    localparam int SSP_CTRL_TDMSEL = 1;
    localparam int SSP_CTRL_ENABLE = 2;
    // status fields
    localparam int SSP_STAT_RXLVL = 0;
    localparam int SSP_STAT_TXLVL = 1;
    localparam int SSP_STAT_READY = 2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SSP_TX_DIV = 4;
    localparam int SSP_WORD_BITS = 16;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic port_enable;
        logic tdm_select;
        logic clock_source_select;
    } ssp_ctrl_t;
    typedef struct packed {
        logic test_reset;
        logic emulation_pin_zero;
        logic emulation_pin_one_or_off;
    } ssp_off_pins_t;
    typedef enum logic {
        SSP_RX_IDLE,
        SSP_RX_SHIFT
    } ssp_rx_state_t;
endpackage

// ===== logic/ssp_pins.sv
// serial port receive path, transmit clock pin and pin readback
// assumes an APB master on ref_clk_i and a partner driving the
// receive clock, frame sync and data in the receive clock domain
`timescale 1ns/1ps
module ssp_pins #(
    parameter int WORD_BITS = ssp_pkg::SSP_WORD_BITS
) (
    // register clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // receive link, clocked by the partner
    input wire logic receive_bit_clock_i,
    input wire logic tdm_receive_bit_clock_i,
    input wire logic receive_frame_sync_i,
    input wire logic tdm_receive_frame_sync_i,
    input wire logic serial_in_pin_i,
    input wire logic tdm_serial_in_pin_i,
    // transmit clock pin, three signals
    input wire logic transmit_bit_clock_i,
    output logic transmit_bit_clock_o,
    output logic transmit_bit_clock_oe_o,
    // test and emulation pins
    input wire ssp_pkg::ssp_off_pins_t off_pins_i
);
    // ------------------------------------------------------------
    // pin synchronisers in the register domain
    // ------------------------------------------------------------
    // rx clock level, tx clock level, three off pins
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    always_ff @(posedge ref_clk_i) begin
        pin_s1_reg <= {receive_bit_clock_i, transmit_bit_clock_i,
                       off_pins_i};
        pin_s2_reg <= pin_s1_reg;
    end
    ssp_pkg::ssp_off_pins_t off_s;
    logic drivers_off;
    assign off_s = pin_s2_reg[2:0];
    assign drivers_off = !off_s.test_reset
        && off_s.emulation_pin_zero
        && !off_s.emulation_pin_one_or_off;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    ssp_pkg::ssp_ctrl_t ctrl_reg, ctrl_next;
    logic [WORD_BITS-1:0] data_reg, data_next;
    logic ready_reg, ready_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic [1:0] div_reg, div_next;
    logic ack_reg, ack_next;
    logic done_s1_reg, done_s2_reg, done_s3_reg;
    logic done_toggle_reg, done_toggle_next;
    logic word_arrived;
    logic [WORD_BITS-1:0] hold_reg;

    function automatic logic ofs_known(input logic [11:0] a);
        ofs_known = (a == ssp_pkg::SSP_CTRL_OFS)
            || (a == ssp_pkg::SSP_STAT_OFS)
            || (a == ssp_pkg::SSP_DATA_OFS);
    endfunction

    logic access;
    assign access = psel_i && penable_i;
    // one wait state: the answer is registered at the edge that raises pready,
    // so read data and error stand at the completing edge
    assign pready_o = ack_reg;
    assign prdata_o = prdata_reg;
    assign pslverr_o = pslverr_reg;

    assign word_arrived = done_s2_reg != done_s3_reg;

    always_comb begin
        ctrl_next = ctrl_reg;
        data_next = data_reg;
        ready_next = ready_reg;
        prdata_next = 32'h0000_0000;
        pslverr_next = 1'b0;
        ack_next = access && !ack_reg;
        div_next = div_reg + 2'h1;
        if (access && !ack_reg && !ofs_known(paddr_i)) begin
            pslverr_next = 1'b1;
        end
        if (access && ack_reg && pwrite_i
                && paddr_i == ssp_pkg::SSP_CTRL_OFS) begin
            ctrl_next = pwdata_i[2:0];
        end
        if (access && !ack_reg && !pwrite_i) begin
            case (paddr_i)
                ssp_pkg::SSP_CTRL_OFS: begin
                    prdata_next[2:0] = ctrl_reg;
                end
                ssp_pkg::SSP_STAT_OFS: begin
                    // levels only shown while the port is unused
                    // receive clock level
                    prdata_next[ssp_pkg::SSP_STAT_RXLVL] =
                        !ctrl_reg.port_enable && pin_s2_reg[4];
                    prdata_next[ssp_pkg::SSP_STAT_TXLVL] =
                        !ctrl_reg.port_enable && pin_s2_reg[3];
                    prdata_next[ssp_pkg::SSP_STAT_READY] = ready_reg;
                end
                ssp_pkg::SSP_DATA_OFS: begin
                    prdata_next[WORD_BITS-1:0] = data_reg;
                    ready_next = 1'b0;
                end
                default: begin
                    prdata_next = 32'h0000_0000;
                end
            endcase
        end
        // a word landing during the clearing read still counts
        if (word_arrived) begin
            data_next = hold_reg;
            ready_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_reg <= ssp_pkg::SSP_CTRL_RST;
            data_reg <= '0;
            ready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            ack_reg <= 1'b0;
            div_reg <= 2'h0;
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
            done_s3_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            data_reg <= data_next;
            ready_reg <= ready_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            ack_reg <= ack_next;
            div_reg <= div_next;
            done_s1_reg <= done_toggle_reg;
            done_s2_reg <= done_s1_reg;
            done_s3_reg <= done_s2_reg;
        end
    end

    // ------------------------------------------------------------
    // transmit clock pin
    // ------------------------------------------------------------
    // quarter-rate output, even duty
    assign transmit_bit_clock_o = div_reg[1];
    // drive only when internal and not off
    assign transmit_bit_clock_oe_o =
        ctrl_reg.clock_source_select && !drivers_off;

    // ------------------------------------------------------------
    // receive domain
    // ------------------------------------------------------------
    // clock, frame sync and data follow the pin selection
    // the clock mux is only safe while the port is idle
    logic rx_clk;
    assign rx_clk = ctrl_reg.tdm_select ? tdm_receive_bit_clock_i
                                        : receive_bit_clock_i;

    logic rrst_s1_reg, rrst_s2_reg;
    logic en_s1_reg, en_s2_reg;
    logic tdm_s1_reg, tdm_s2_reg;
    ssp_pkg::ssp_rx_state_t rx_state_reg, rx_state_next;
    logic [WORD_BITS-1:0] receive_shift_reg, shift_next;
    logic [WORD_BITS-1:0] hold_next;
    logic [$clog2(WORD_BITS)-1:0] bit_cnt_reg, bit_cnt_next;
    logic fs_prev_reg;
    logic fs_now, din_now;

    always_ff @(posedge rx_clk) begin
        rrst_s1_reg <= rst_i;
        rrst_s2_reg <= rrst_s1_reg;
        en_s1_reg <= ctrl_reg.port_enable;
        en_s2_reg <= en_s1_reg;
        tdm_s1_reg <= ctrl_reg.tdm_select;
        tdm_s2_reg <= tdm_s1_reg;
    end

    assign fs_now = tdm_s2_reg ? tdm_receive_frame_sync_i
                               : receive_frame_sync_i;
    assign din_now = tdm_s2_reg ? tdm_serial_in_pin_i
                                : serial_in_pin_i;

    always_comb begin
        rx_state_next = rx_state_reg;
        shift_next = receive_shift_reg;
        hold_next = hold_reg;
        bit_cnt_next = bit_cnt_reg;
        done_toggle_next = done_toggle_reg;
        case (rx_state_reg)
            ssp_pkg::SSP_RX_IDLE: begin
                if (en_s2_reg && fs_prev_reg && !fs_now) begin
                    shift_next = {receive_shift_reg[WORD_BITS-2:0],
                                  din_now};
                    bit_cnt_next = '0;
                    rx_state_next = ssp_pkg::SSP_RX_SHIFT;
                end
            end
            ssp_pkg::SSP_RX_SHIFT: begin
                shift_next = {receive_shift_reg[WORD_BITS-2:0],
                              din_now};
                bit_cnt_next = bit_cnt_reg + 1'b1;
                if (bit_cnt_reg == ($clog2(WORD_BITS))'(WORD_BITS - 2))
                begin
                    // word held steady for the crossing
                    hold_next = shift_next;
                    done_toggle_next = !done_toggle_reg;
                    rx_state_next = ssp_pkg::SSP_RX_IDLE;
                end
            end
            default: begin
                rx_state_next = ssp_pkg::SSP_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge rx_clk) begin
        if (rrst_s2_reg) begin
            rx_state_reg <= ssp_pkg::SSP_RX_IDLE;
            receive_shift_reg <= '0;
            hold_reg <= '0;
            bit_cnt_reg <= '0;
            // idle level of frame sync, so no false start after reset
            fs_prev_reg <= 1'b1;
            done_toggle_reg <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            receive_shift_reg <= shift_next;
            hold_reg <= hold_next;
            bit_cnt_reg <= bit_cnt_next;
            fs_prev_reg <= fs_now;
            done_toggle_reg <= done_toggle_next;
        end
    end
endmodule

// ===== test/ssp_pins_props.sv
// checker for the serial port pin block
// assumes it is bound to ssp_pins and sees only its ports
`timescale 1ns/1ps
module ssp_pins_props (
    // clock, reset and apb
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // transmit clock pin and test pins
    input wire logic transmit_bit_clock_o,
    input wire logic transmit_bit_clock_oe_o,
    input wire ssp_pkg::ssp_off_pins_t off_pins_i
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic acc, map, off, oe, tx;
    assign acc = psel_i && penable_i;
    assign map = paddr_i inside {ssp_pkg::SSP_CTRL_OFS,
        ssp_pkg::SSP_STAT_OFS, ssp_pkg::SSP_DATA_OFS};
    assign off = !off_pins_i.test_reset && off_pins_i.emulation_pin_zero
        && !off_pins_i.emulation_pin_one_or_off;
    assign oe = transmit_bit_clock_oe_o;
    assign tx = transmit_bit_clock_o;
    a_ready_wait: assert property (acc && !$past(acc)
        |-> !pready_o ##1 pready_o)
        else $error("pready not after one wait state");
    a_err_unmapped: assert property (acc && pready_o && !map
        |-> pslverr_o)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (acc && pready_o && map
        |-> !pslverr_o)
        else $error("error on mapped access");
    a_err_cause: assert property (pslverr_o |-> $past(acc && !map))
        else $error("error without cause");
    a_rd_quiet: assert property (!$past(acc && !pwrite_i)
        |-> prdata_o == 32'h0)
        else $error("read data outside read");
    a_rst_quiet: assert property ($past(rst_i) |-> !oe && !pslverr_o)
        else $error("outputs active after reset");
    // the pins pass two sync stages, so the float may trail them
    a_off_float: assert property (off && $past(off)
        && $past(off, 2) && $past(off, 3) |-> !oe)
        else $error("transmit clock driven while off");
    a_tx_quarter: assert property (oe && $past(oe)
        && $past(oe, 2) |-> tx != $past(tx, 2))
        else $error("transmit clock not a quarter rate");
endmodule
bind ssp_pins ssp_pins_props ssp_pins_props_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .transmit_bit_clock_o(transmit_bit_clock_o),
    .transmit_bit_clock_oe_o(transmit_bit_clock_oe_o),
    .off_pins_i(off_pins_i));

// ===== test/ssp_far_model.sv
// far-side serial peripheral sending one word per go pulse
// assumes the bench holds tdm_i steady while busy_o is high
`timescale 1ns/1ps
module ssp_far_model (
    // control from the bench
    input wire logic go_i,
    input wire logic tdm_i,
    input wire logic idle_i,
    input wire logic [15:0] word_i,
    // link pins
    output logic clk_o,
    output logic tclk_o,
    output logic fs_o,
    output logic tfs_o,
    output logic d_o,
    output logic td_o,
    output logic busy_o
);
    logic c, f, d, ck;
    assign ck = busy_o ? c : idle_i;
    assign clk_o = tdm_i ? idle_i : ck;
    assign tclk_o = tdm_i ? ck : idle_i;
    assign fs_o = tdm_i ? 1'b1 : f;
    assign tfs_o = tdm_i ? f : 1'b1;
    // unused data line shows the inverse, never a stale bit
    assign d_o = tdm_i ? ~d : d;
    assign td_o = tdm_i ? d : ~d;
    task automatic bit_out(input logic v, input logic s);
        c = 0; d = v; f = s; #7.5; c = 1; #7.5;
    endtask
    initial begin
        c = 0; f = 1; d = 0; busy_o = 1;
        repeat (4) bit_out(1'b0, 1'b1);
        busy_o = 0;
        forever begin
            wait (go_i === 1'b1);
            // clock low first, so enabling it makes no rising edge
            c = 0;
            busy_o = 1;
            // lead-in edges let the port's link-side syncs settle
            repeat (4) bit_out(d, 1'b1);
            // frame sync falls with the first bit, msb first
            for (int i = 15; i >= 0; i--) bit_out(word_i[i], i != 15);
            repeat (2) bit_out(~d, 1'b1);
            d = ~d; busy_o = 0;
            wait (go_i === 1'b0);
        end
    end
endmodule

// ===== test/test_ssp_pins.sv
// random and corner tests of the serial port pin block
// assumes the far-side model and the bound checker
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin \
    n_fail++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module test_ssp_pins;
    localparam logic [11:0] CT = ssp_pkg::SSP_CTRL_OFS;
    localparam logic [11:0] ST = ssp_pkg::SSP_STAT_OFS;
    logic ref_clk_i, rst_i, psel, pen, pwr, pready, perr, er;
    logic go, tdm, idle, txin, txo, txoe, txpin, busy;
    logic rck, tck, fs, tfs, d, td;
    logic [11:0] pa;
    logic [31:0] pwd, prd, rd;
    logic [15:0] word;
    ssp_pkg::ssp_off_pins_t off;
    int n_fail, samples_checked, seed, k, t;
    assign txpin = txoe ? txo : txin;
    ssp_pins ssp_pins_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
        .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready),
        .pslverr_o(perr), .receive_bit_clock_i(rck),
        .tdm_receive_bit_clock_i(tck), .receive_frame_sync_i(fs),
        .tdm_receive_frame_sync_i(tfs), .serial_in_pin_i(d),
        .tdm_serial_in_pin_i(td), .transmit_bit_clock_i(txpin),
        .transmit_bit_clock_o(txo), .transmit_bit_clock_oe_o(txoe),
        .off_pins_i(off));
    ssp_far_model ssp_far_model_i (.go_i(go), .tdm_i(tdm), .idle_i(idle),
        .word_i(word), .clk_o(rck), .tclk_o(tck), .fs_o(fs),
        .tfs_o(tfs), .d_o(d), .td_o(td), .busy_o(busy));
    initial begin
        ref_clk_i = 0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // read data and error are taken at the edge where pready is high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd);
        int wt;
        @(posedge ref_clk_i);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        pa <= a;
        pwd <= wd;
        @(posedge ref_clk_i);
        pen <= 1;
        wt = 0;
        do begin
            @(posedge ref_clk_i);
            wt++;
        end while (pready !== 1'b1 && wt < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            test_done();
        end
        rd = prd;
        er = perr;
        psel <= 0;
        pen <= 0;
    endtask
    function automatic logic [31:0] stat_exp(input logic en, input logic r,
        input logic rx, input logic tx);
        return en ? {29'h0, r, 2'h0} : {29'h0, r, tx, rx};
    endfunction
    initial begin
        seed = 32'hB0E232AD; rst_i = 1; psel = 0; pen = 0; pwr = 0;
        pa = 0; pwd = 0; go = 0; tdm = 0; idle = 0; txin = 0; word = 0;
        off = 3'h4; n_fail = 0; samples_checked = 0;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 0;
        apb(0, CT, 32'h0);
        `CHK("ctrl reset", 32'h0, rd)
        for (t = 0; t < 4; t++) begin
            @(posedge ref_clk_i);
            idle <= t[0]; txin <= t[1];
            repeat (8) @(posedge ref_clk_i);
            apb(0, ST, 32'h0);
            `CHK("stat idle", stat_exp(0, 0, t[0], t[1]), rd)
        end
        apb(1, 12'h00C, 32'h7);
        `CHK("err", 1'b1, er)
        apb(0, CT, 32'h0);
        `CHK("ctrl kept", 32'h0, rd)
        $display("test readback done");
        apb(1, CT, 32'h1);
        repeat (4) @(negedge ref_clk_i);
        `CHK("oe on", 1'b1, txoe)
        for (t = 0; t < 2; t++) begin
            @(posedge ref_clk_i);
            off <= t[0] ? 3'h0 : 3'h2;
            repeat (5) @(negedge ref_clk_i);
            `CHK("oe off", t[0], txoe)
        end
        @(posedge ref_clk_i);
        off <= 3'h4;
        apb(1, CT, 32'h0);
        repeat (4) @(negedge ref_clk_i);
        `CHK("oe input", 1'b0, txoe)
        $display("test transmit clock done");
        for (t = 0; t < 5; t++) begin
            @(posedge ref_clk_i);
            tdm <= t[0];
            idle <= 0;
            word <= (t == 2) ? 16'h8001 : 16'($random(seed));
            apb(1, CT, {29'h0, t < 4, t[0], 1'b0});
            @(posedge ref_clk_i);
            go <= 1;
            k = 0;
            while (busy !== 1'b1 && k < 10) begin @(posedge ref_clk_i); k++; end
            while (busy !== 1'b0 && k < 40) begin @(posedge ref_clk_i); k++; end
            go <= 0;
            if (k >= 40) begin n_fail++; test_done(); end
            do apb(0, ST, 32'h0); while (rd[2] !== 1'b1 && k++ < 48);
            `CHK("ready", t < 4, rd[2])
            if (t < 4) begin
                apb(0, ssp_pkg::SSP_DATA_OFS, 32'h0);
                `CHK("word", {16'h0, word}, rd)
                apb(0, ST, 32'h0);
                `CHK("stat busy", stat_exp(1, 0, 0, 0), rd)
            end
        end
        $display("test receive done");
        test_done();
    end
endmodule
